// File: src/beam_blanking_defs.vh
// constants for the beam blanking evaluator: offsets, fields, resets
// assumes inclusion by the evaluator only; definitions only
//
// Overview of operation
// R1 - monitored floating: one adjacent group only
// R2 - monitored floating: extra beam opens outputs
// R3 - monitored floating: split group opens outputs
// R4 - reduced resolution tolerates runs up to count
// R5 - reduced resolution: longer run opens outputs
// R6 - reduced resolution ignores monitoring setting
// R7 - reduced resolution measures each run separately
// R8 - four regions, each with own mode
// R9 - lamp fault while blanking forces lockout
// R10 - monitored group may be one beam short
// R11 - unmonitored: up to count, none required
// R12 - unblanked interrupted beam opens outputs
// R13 - every scan re-evaluated, outputs updated
`ifndef BEAM_BLANKING_DEFS_VH
`define BEAM_BLANKING_DEFS_VH

// ==========================================
// array size
`define BEAMS 60
`define BEAM_W 6
`define REGIONS 4

// ==========================================
// register byte offsets
`define OFF_CTRL 12'h000
`define OFF_STAT 12'h004
`define OFF_IRQ_STAT 12'h008
`define OFF_IRQ_CLR 12'h00C
`define OFF_IRQ_EN 12'h010
`define OFF_REGION0 12'h020
`define OFF_REGION3 12'h02C

// ==========================================
// control fields
`define CTRL_BLANK_EN 0
`define CTRL_OSB_LO 4
`define CTRL_OSB_HI 5
`define CTRL_RESET 32'h00000030

// region fields: first beam, last beam, mode, beam count
`define REG_LO_LSB 0
`define REG_HI_LSB 8
`define REG_MODE_LSB 16
`define REG_CNT_LSB 24
`define REGION_RESET 32'h05000000

// blanking modes
`define MODE_NONE 2'h0
`define MODE_FLOAT_MON 2'h1
`define MODE_FLOAT_FREE 2'h2
`define MODE_REDUCED 2'h3

// interrupt events
`define EV_OPEN 0
`define EV_LOCK 1
`define EV_SCAN 2
`define EV_W 3

`endif

// File: src/beam_blanking_evaluator.v
// beam blanking evaluator: checks each scan of the beam array against
// four blanking regions, drives the safety output blocks and the lamp.
// assumes beam vector and scan strobe come from the receiver's clock,
// beam data stable around the strobe; lamp sense is an async pin.
`timescale 1ns/1ns
`include "beam_blanking_defs.vh"

module beam_blanking_evaluator (
  // clock, reset, freeze
  input wire pclk,
  input wire presetn,
  input wire ce,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // beam receiver array
  input wire [`BEAMS-1:0] beam_blocked,
  input wire scan_done,
  // blanking lamp
  input wire lamp_sense_ok,
  output reg lamp_on,
  // safety outputs and interrupt
  output reg [1:0] safety_output_block,
  output reg lockout,
  output reg irq
);

  // ==========================================
  // evaluation of one region

  // returns 1 when the region's pattern is not permitted
  // runs are counted inside the region only, so a group never
  // merges with interrupted beams of a neighbouring region
  function region_bad;
    input [`BEAMS-1:0] b;
    input [`BEAM_W-1:0] lo;
    input [`BEAM_W-1:0] hi;
    input [1:0] md;
    input [`BEAM_W-1:0] n;
    integer i;
    reg [6:0] run;
    reg [6:0] mx;
    reg [6:0] tot;
    reg [6:0] runs;
    reg [6:0] n7;
    begin
      run = 7'h00;
      mx = 7'h00;
      tot = 7'h00;
      runs = 7'h00;
      n7 = {1'b0, n};
      for (i = 0; i < `BEAMS; i = i + 1) begin
        if (i >= lo && i <= hi && b[i]) begin
          if (run == 7'h00)
            runs = runs + 7'h01; // each run counted on its own
          run = run + 7'h01;
          tot = tot + 7'h01;
          if (run > mx)
            mx = run;
        end else begin
          run = 7'h00;
        end
      end
      case (md)
        `MODE_FLOAT_MON: begin
          // exactly one group, full count or one short
          region_bad = (runs != 7'h01) || // R1 R2 R3
                       (tot != n7 && tot + 7'h01 != n7); // R10
        end
        `MODE_FLOAT_FREE: begin
          // beams may be absent; only the total is bounded
          region_bad = (tot > n7); // R11
        end
        `MODE_REDUCED: begin
          // longest run only; several short runs pass
          region_bad = (mx > n7); // R4 R5 R6 R7
        end
        default: begin
          // no blanking: any beam in the region opens
          region_bad = (tot != 7'h00); // R12
        end
      endcase
    end
  endfunction

  // mask of beams covered by a region with a blanking mode
  function [`BEAMS-1:0] cover_mask;
    input [`BEAM_W-1:0] lo;
    input [`BEAM_W-1:0] hi;
    input [1:0] md;
    integer i;
    begin
      cover_mask = {`BEAMS{1'b0}};
      for (i = 0; i < `BEAMS; i = i + 1)
        cover_mask[i] = (md != `MODE_NONE) && i >= lo && i <= hi;
    end
  endfunction

  // ==========================================
  // registers and synchronisers

  reg [31:0] ctrl_reg;
  reg [31:0] region_reg [0:`REGIONS-1];
  reg [`EV_W-1:0] irq_stat_reg;
  reg [`EV_W-1:0] irq_en_reg;
  reg [`BEAMS-1:0] beam_s1_reg;
  reg [`BEAMS-1:0] beam_s2_reg;
  reg [2:0] scan_sync_reg;
  reg [1:0] lamp_sync_reg;
  reg [`REGIONS-1:0] viol_reg;
  reg loose_reg;
  integer k;
  integer j;

  wire blank_en = ctrl_reg[`CTRL_BLANK_EN];
  wire [1:0] osb_sel = ctrl_reg[`CTRL_OSB_HI:`CTRL_OSB_LO];
  wire scan_edge = scan_sync_reg[1] & ~scan_sync_reg[2];
  wire lamp_fault = blank_en & ~lamp_sync_reg[1];

  // ==========================================
  // combinational evaluation of the synchronised scan

  reg [`REGIONS-1:0] viol_next;
  reg [`BEAMS-1:0] cover_next;
  reg loose_next;
  reg open_next;

  always @* begin
    cover_next = {`BEAMS{1'b0}};
    for (k = 0; k < `REGIONS; k = k + 1) begin
      // region evaluated only while blanking is enabled
      viol_next[k] = blank_en && region_bad(beam_s2_reg, // R8
        region_reg[k][`REG_LO_LSB +: `BEAM_W],
        region_reg[k][`REG_HI_LSB +: `BEAM_W],
        region_reg[k][`REG_MODE_LSB +: 2],
        region_reg[k][`REG_CNT_LSB +: `BEAM_W]);
      if (blank_en)
        cover_next = cover_next | cover_mask(
          region_reg[k][`REG_LO_LSB +: `BEAM_W],
          region_reg[k][`REG_HI_LSB +: `BEAM_W],
          region_reg[k][`REG_MODE_LSB +: 2]);
    end
    loose_next = |(beam_s2_reg & ~cover_next); // R12
    open_next = loose_next | (|viol_next);
  end

  // ==========================================
  // input synchronisers

  // two stages for beams and lamp, a third for the scan edge
  // beams are taken bit by bit; the scan protocol keeps them steady
  // around the strobe, so the sampled pattern is coherent
  // only stage two reads stage one; lamp sense resets low, which is
  // harmless because blanking resets off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beam_s1_reg <= {`BEAMS{1'b0}};
      beam_s2_reg <= {`BEAMS{1'b0}};
      scan_sync_reg <= 3'h0;
      lamp_sync_reg <= 2'h0;
    end else if (ce) begin
      beam_s1_reg <= beam_blocked;
      beam_s2_reg <= beam_s1_reg;
      scan_sync_reg <= {scan_sync_reg[1:0], scan_done};
      lamp_sync_reg <= {lamp_sync_reg[0], lamp_sense_ok};
    end
  end

  // ==========================================
  // safety outputs, lockout, lamp

  // outputs follow each completed scan; lockout holds until reset
  // a lamp fault overrides any scan so the blocks never stay closed
  // without a working indication; lockout is left only through presetn
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_reg <= {`REGIONS{1'b0}};
      loose_reg <= 1'b0;
      safety_output_block <= 2'h0;
      lockout <= 1'b0;
      lamp_on <= 1'b0;
    end else if (ce) begin
      lamp_on <= blank_en;
      if (lamp_fault)
        lockout <= 1'b1; // R9
      if (lamp_fault || lockout) begin
        safety_output_block <= 2'h0; // R9
      end else if (scan_edge) begin
        viol_reg <= viol_next; // R13
        loose_reg <= loose_next;
        safety_output_block <= open_next ? 2'h0 : osb_sel; // R2 R5 R13
      end
    end
  end

  // ==========================================
  // apb slave

  // a write lands at the edge that samples pready high
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  // exact decode: any other address answers with pslverr
  wire is_region = paddr >= `OFF_REGION0 && paddr <= `OFF_REGION3 &&
                   paddr[1:0] == 2'h0;
  wire [1:0] ridx = paddr[3:2];
  wire mapped = is_region || paddr == `OFF_CTRL || paddr == `OFF_STAT ||
                paddr == `OFF_IRQ_STAT || paddr == `OFF_IRQ_CLR ||
                paddr == `OFF_IRQ_EN;

  // read data for the addressed register
  // the write-only clear register and holes read as zero
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h00000000;
    if (is_region)
      rd_next = region_reg[ridx];
    else if (paddr == `OFF_CTRL)
      rd_next = ctrl_reg;
    else if (paddr == `OFF_STAT)
      rd_next = {22'h000000, viol_reg, loose_reg, lockout, lamp_sync_reg[1],
                 lamp_on, safety_output_block};
    else if (paddr == `OFF_IRQ_STAT)
      rd_next = {29'h00000000, irq_stat_reg};
    else if (paddr == `OFF_IRQ_EN)
      rd_next = {29'h00000000, irq_en_reg};
  end

  // one wait state: pready rises in the second access cycle
  // pready resets low and drops after each answer, a one-cycle
  // pulse; prdata holds between answers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        pslverr <= ~mapped;
        prdata <= pwrite ? 32'h00000000 : rd_next;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // writable configuration
  // reserved bits are stored as zero so reads show only real fields
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET;
      irq_en_reg <= {`EV_W{1'b0}};
      for (j = 0; j < `REGIONS; j = j + 1)
        region_reg[j] <= `REGION_RESET;
    end else if (ce && wr) begin
      if (paddr == `OFF_CTRL)
        ctrl_reg <= {26'h0000000, pwdata[`CTRL_OSB_HI:`CTRL_OSB_LO], 3'h0,
                     pwdata[`CTRL_BLANK_EN]};
      if (paddr == `OFF_IRQ_EN)
        irq_en_reg <= pwdata[`EV_W-1:0];
      if (is_region)
        region_reg[ridx] <= {2'h0, pwdata[`REG_CNT_LSB +: `BEAM_W], 6'h00,
                             pwdata[`REG_MODE_LSB +: 2], 2'h0,
                             pwdata[`REG_HI_LSB +: `BEAM_W], 2'h0,
                             pwdata[`REG_LO_LSB +: `BEAM_W]};
    end
  end

  // ==========================================
  // interrupts

  // events are one-cycle pulses from this cycle's state
  reg [`EV_W-1:0] ev;
  reg [`EV_W-1:0] clr;
  reg [`EV_W-1:0] irq_stat_next;
  always @* begin
    ev = {`EV_W{1'b0}};
    ev[`EV_OPEN] = scan_edge & open_next & ~lockout;
    ev[`EV_LOCK] = lamp_fault & ~lockout;
    ev[`EV_SCAN] = scan_edge;
    clr = (wr && paddr == `OFF_IRQ_CLR) ? pwdata[`EV_W-1:0] : {`EV_W{1'b0}};
    irq_stat_next = (irq_stat_reg & ~clr) | ev; // event wins over clear
  end

  // sticky status; irq from the same next value, so it never lags it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= {`EV_W{1'b0}};
      irq <= 1'b0;
    end else if (ce) begin
      irq_stat_reg <= irq_stat_next;
      irq <= |(irq_stat_next & irq_en_reg);
    end
  end

endmodule // beam_blanking_evaluator

// File: tb/beam_blanking_evaluator_sva.sv
// checker on the evaluator's ports: apb answer, scan outputs, lockout
// assumes one pclk domain with presetn async low; bound below
`timescale 1ns/1ns
module beam_blanking_evaluator_sva (
  // clock, reset, apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // receiver, lamp, outputs
  input wire scan_done,
  input wire lamp_sense_ok,
  input wire lamp_on,
  input wire [1:0] safety_output_block,
  input wire lockout
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // lockout
  property p_lock_open; lockout |-> safety_output_block == 2'h0; endproperty
  a_lock_open: assert property (p_lock_open) else $error("blocks closed in lockout");
  property p_lock_hold; lockout |=> lockout; endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockout left");
  property p_lamp_fault; (lamp_on && !lamp_sense_ok) [*3] |-> ##[0:2] lockout; endproperty
  a_lamp_fault: assert property (p_lamp_fault) else $error("lamp fault missed");
  property p_lock_cause; $rose(lockout) |-> $past(lamp_on); endproperty
  a_lock_cause: assert property (p_lock_cause) else $error("lockout unblanked");
  // ==========================================
  // scan evaluation and apb
  property p_scan_cause;
    $changed(safety_output_block) && !lockout |-> $past(scan_done, 3) || $past(scan_done, 6);
  endproperty
  a_scan_cause: assert property (p_scan_cause) else $error("outputs moved without scan");
  property p_pready_pulse; pready |=> !pready; endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready too long");
  property p_pready_cause; pready |-> psel && penable; endproperty
  a_pready_cause: assert property (p_pready_cause) else $error("pready without access");
  property p_err_pair; pslverr |-> pready; endproperty
  a_err_pair: assert property (p_err_pair) else $error("pslverr alone");
  // main scenarios reached
  c_closed: cover property (safety_output_block == 2'h3);
  c_lock: cover property ($rose(lockout));
  c_err: cover property (pready && pslverr);
endmodule // beam_blanking_evaluator_sva

bind beam_blanking_evaluator beam_blanking_evaluator_sva u_beam_blanking_evaluator_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .scan_done(scan_done), .lamp_sense_ok(lamp_sense_ok),
  .lamp_on(lamp_on), .safety_output_block(safety_output_block), .lockout(lockout));

// File: tb/beam_array_model.sv
// receiver beam array and blanking lamp facing the evaluator
// assumes pclk from the bench; every change right after a rising edge
`timescale 1ns/1ns
module beam_array_model (
  // clock
  input wire pclk,
  // beams, scan strobe, lamp
  output reg [59:0] beam_blocked,
  output reg scan_done,
  output reg lamp_sense_ok
);
  // idle: clear field, lamp good
  initial begin
    beam_blocked = 60'h0;
    scan_done = 1'b0;
    lamp_sense_ok = 1'b1;
  end
  // one scan: beams settle 3 cycles, strobe 4, gap 8
  task scan(input [59:0] b);
    begin
      @(posedge pclk) beam_blocked <= b;
      repeat (3) @(posedge pclk);
      scan_done <= 1'b1;
      repeat (4) @(posedge pclk);
      scan_done <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask
  // lamp circuit opens and stays open
  task lamp_cut;
    @(posedge pclk) lamp_sense_ok <= 1'b0;
  endtask
endmodule // beam_array_model

// File: tb/beam_blanking_evaluator_tb_top.sv
// self-checking bench: apb setup of four regions, scans, irq, lamp fault
// assumes the evaluator, its checker and the beam array model
`timescale 1ns/1ns
module beam_blanking_evaluator_tb_top;
  reg pclk, presetn, ce, psel, penable, pwrite, err;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, scan_done, lamp_sense_ok, lamp_on, lockout, irq;
  wire [59:0] beam_blocked;
  wire [1:0] safety_output_block;
  integer errors, samples_checked;
  wire [59:0] b0 = 60'h0000000000FC00;
  beam_blanking_evaluator u_beam_blanking_evaluator (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .beam_blocked(beam_blocked), .scan_done(scan_done), .lamp_sense_ok(lamp_sense_ok),
    .lamp_on(lamp_on), .safety_output_block(safety_output_block), .lockout(lockout),
    .irq(irq));
  beam_array_model u_beam_array_model (.pclk(pclk), .beam_blocked(beam_blocked),
    .scan_done(scan_done), .lamp_sense_ok(lamp_sense_ok));
  // clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // apb transfer, held until pready is sampled high
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  function [59:0] run(input integer lo, input integer n);
    run = ((60'h1 << n) - 60'h1) << lo;
  endfunction
  task chk(input [59:0] b, input [1:0] e);
    begin
      u_beam_array_model.scan(b);
      cmp({30'h0, safety_output_block}, {30'h0, e});
    end
  endtask
  // hang guard
  initial begin
    #(40 * 20000);
    errors = errors + 1;
    finish_test;
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    ce = 1'b1;
    errors = 0;
    samples_checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h000, 0);
    cmp(rd, 32'h00000030);
    apb(0, 12'h020, 0);
    cmp(rd, 32'h05000000);
    apb(0, 12'h0FC, 0);
    cmp({31'h0, err}, 32'h1);
    apb(1, 12'h000, 32'h00000031);
    apb(1, 12'h020, 32'h06011D0A);
    apb(1, 12'h024, 32'h0503311E);
    apb(1, 12'h028, 32'h03023B32);
    apb(1, 12'h02C, 32'h02030400);
    cmp({31'h0, lamp_on}, 32'h1);
    $display("test apb done");
    chk(60'h0, 2'h0);
    chk(b0, 2'h3);
    chk(run(20, 6), 2'h3);
    chk(run(11, 5), 2'h3);
    chk(run(12, 4), 2'h0);
    chk(run(10, 7), 2'h0);
    chk(b0 | run(20, 1), 2'h0);
    chk(run(10, 3) | run(14, 2), 2'h0);
    chk(b0 | run(30, 5) | run(36, 2), 2'h3);
    chk(b0 | run(30, 3) | run(34, 2) | run(37, 4), 2'h3);
    chk(b0 | run(30, 6), 2'h0);
    chk(b0 | run(40, 1), 2'h3);
    chk(b0 | run(50, 1) | run(53, 1) | run(58, 1), 2'h3);
    chk(b0 | run(50, 4), 2'h0);
    chk(b0 | run(0, 2), 2'h3);
    chk(b0 | run(0, 3), 2'h0);
    chk(b0 | run(5, 1), 2'h0);
    chk(b0, 2'h3);
    $display("test scan done");
    ce <= 1'b0;
    chk(b0 | run(5, 1), 2'h3);
    ce <= 1'b1;
    $display("test freeze done");
    cmp({31'h0, irq}, 32'h0);
    apb(1, 12'h010, 32'h00000004);
    repeat (2) @(posedge pclk);
    cmp({31'h0, irq}, 32'h1);
    apb(0, 12'h008, 0);
    cmp(rd, 32'h00000005);
    apb(1, 12'h00C, 32'h00000004);
    repeat (2) @(posedge pclk);
    cmp({31'h0, irq}, 32'h0);
    $display("test irq done");
    u_beam_array_model.lamp_cut;
    repeat (6) @(posedge pclk);
    cmp({31'h0, lockout}, 32'h1);
    chk(b0, 2'h0);
    apb(0, 12'h004, 0);
    cmp(rd, 32'h00000014);
    apb(0, 12'h008, 0);
    cmp(rd, 32'h00000007);
    $display("test lamp done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    cmp({31'h0, lockout}, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    $display("test reset done");
    finish_test;
  end
endmodule // beam_blanking_evaluator_tb_top
